// File: epb_master.sv
// Bus-master end: runs one external read or write at a time.
// Assumes the ack pull-up lives outside this module; the ack keeper is inside it.
// Wait states come only from the ack pin; there is no wait generator.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: 32-bit words use data lines 47-16
// R2: 40-bit words use data lines 47-8
// R3: 16-bit words use data lines 31-16
// R4: Boot bytes arrive on data lines 23-16
// R5: One low-active chip select per bank
// R6: Selects decoded, switch with address
// R7: Selects idle unless access; conditional still selects
// R8: Page flag on DRAM page crossing
// R9: Page flag only for bank 0
// R10: Read strobe low on master reads
// R11: Outside master strobes to reach memory
// R12: Write strobe low on master writes
// R13: Only bus master drives strobes
// R14: Early store select with address, abortable
// R15: Slave classifies access by store select
// R16: Host asserts store select on sync writes
// R17: Low ack holds off access completion
// R18: Slave pulls ack low for waits
// R19: Master keeps last ack level
// R20: Slave accepts address from outside master
// R21: Master drives address for remote access
// R22: Asynchronous inputs synchronised before use; the slave uses the bus inputs directly, with no resync
// R23: Each low ack sample adds a cycle
module epb_master
    import epb_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Request from core
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic              req_write_i,
    input  wire logic              req_cond_true_i,
    input  wire epb_fmt_t          req_fmt_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [39:0]       req_wdata_i,
    input  wire logic              is_master_i,
    // Completion
    output logic                   done_o,
    output logic [39:0]            rdata_o,
    // Bus pins
    epb_if.master                  bus
);
    typedef enum logic [1:0] {EPB_IDLE, EPB_ADDR, EPB_STROBE} epb_st_t;

    typedef struct packed {
        epb_st_t           st;
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              cond;
        epb_fmt_t          fmt;
        logic [DATA_W-1:0] wdata;
        logic [BANKS-1:0]  sel_n;
        logic              page;
        logic              pg_valid;
        logic [ADDR_W-1:0] last_page;
        logic              ack_keep;
        logic              done;
        logic [39:0]       rdata;
    } epb_mst_t;

    epb_mst_t         s_q;
    epb_mst_t         s_d;
    logic             ack_eff;
    logic [BANKS-1:0] req_sel_n;
    logic             rd_n_c;
    logic             wr_n_c;
    logic             early_n_c;
    logic             wdata_oe_c;

    // Bank field of an address
    function automatic logic [BANK_W-1:0] bank_of(
        input logic [ADDR_W-1:0] a);
        return a[BANK_LO+:BANK_W];
    endfunction

    // DRAM may sit in one bank only, so the page flag is gated by it
    function automatic logic in_dram(input logic [ADDR_W-1:0] a);
        return bank_of(a) == BANK_DRAM;
    endfunction

    // Same DRAM page means equal bits from PAGE_LO upwards
    function automatic logic same_page(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] b);
        return a[ADDR_W-1:PAGE_LO] == b[ADDR_W-1:PAGE_LO];
    endfunction

    // One compare per bank keeps every select line on the same timing
    for (genvar b = 0; b < BANKS; b++)
    begin : g_bank_sel
        assign req_sel_n[b] = (bank_of(req_addr_i) != BANK_W'(b)); // R5 R6
    end

    // Keeper: hold last level when ack is undriven (x/z) outside
    assign ack_eff = (bus.ack === 1'b0) ? 1'b0 :
                     (bus.ack === 1'b1) ? 1'b1 : s_q.ack_keep; // R19

    always_comb
    begin
        s_d          = s_q;
        s_d.done     = 1'b0;
        s_d.ack_keep = ack_eff; // R19
        case (s_q.st)
            EPB_IDLE:
            begin
                s_d.sel_n = SEL_IDLE; // R7
                s_d.page  = 1'b0;
                if (req_valid_i && is_master_i)
                begin
                    s_d.st    = EPB_ADDR;
                    s_d.addr  = req_addr_i; // R21
                    s_d.write = req_write_i;
                    s_d.cond  = req_cond_true_i;
                    s_d.fmt   = req_fmt_i;
                    s_d.wdata = epb_pack(req_fmt_i, req_wdata_i); // R1 R2 R3
                    // Selects go active even for a false condition
                    s_d.sel_n = req_sel_n; // R5 R6 R7
                    s_d.page  = in_dram(req_addr_i) && s_q.pg_valid &&
                        !same_page(req_addr_i, s_q.last_page); // R8 R9
                    if (in_dram(req_addr_i))
                    begin
                        s_d.pg_valid  = 1'b1;
                        s_d.last_page = req_addr_i;
                    end
                end
            end
            EPB_ADDR:
            begin
                // A false condition abandons the cycle before the strobe
                s_d.st = s_q.cond ? EPB_STROBE : EPB_IDLE; // R14
                s_d.done = !s_q.cond;
                if (!s_q.cond)
                    s_d.sel_n = SEL_IDLE;
            end
            EPB_STROBE:
            begin
                if (ack_eff) // R17 R23
                begin
                    s_d.st    = EPB_IDLE;
                    s_d.done  = 1'b1;
                    s_d.sel_n = SEL_IDLE;
                    s_d.page  = 1'b0;
                    if (!s_q.write)
                        s_d.rdata = epb_unpack(s_q.fmt, bus.s_data); // R4
                end
            end
            default: s_d.st = EPB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_q          <= '0;
            s_q.st       <= EPB_IDLE;
            s_q.sel_n    <= SEL_IDLE;
            s_q.ack_keep <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign req_ready_o = (s_q.st == EPB_IDLE) && is_master_i;
    assign done_o      = s_q.done;
    assign rdata_o     = s_q.rdata;

    assign bus.addr               = s_q.addr;
    assign bus.addr_oe            = is_master_i; // R21
    assign bus.bank_chip_select_n = s_q.sel_n;
    assign bus.page               = s_q.page;
    assign bus.strobe_oe          = is_master_i; // R13

    // Strobes come straight from state: low from the cycle after the
    // address phase up to the edge at which ack is seen high
    always_comb
    begin
        rd_n_c     = 1'b1;
        wr_n_c     = 1'b1;
        early_n_c  = 1'b1;
        wdata_oe_c = 1'b0;
        // Warning stands with the address; an abort drops it unanswered
        if ((s_q.st != EPB_IDLE) && s_q.write)
            early_n_c = 1'b0; // R14
        if (s_q.st == EPB_STROBE)
        begin
            if (s_q.write)
            begin
                wr_n_c     = 1'b0; // R12
                wdata_oe_c = is_master_i;
            end
            else
                rd_n_c = 1'b0; // R10
        end
    end

    assign bus.early_store_select_n = early_n_c; // R14
    assign bus.rd_n                 = rd_n_c; // R10
    assign bus.wr_n                 = wr_n_c; // R12
    assign bus.m_data               = s_q.wdata;
    assign bus.m_data_oe            = wdata_oe_c;
endmodule
`default_nettype wire

// File: epb_pkg.sv
// Shared constants and types for the external port bus, both ends.
// Assumes a single 100 MHz clock shared by both ends.
package epb_pkg;
    localparam int ADDR_W  = 32;
    localparam int DATA_W  = 48;
    localparam int BANKS   = 4;
    // Bank and page decode bits (plain defaults)
    localparam int BANK_LO = 26;
    localparam int BANK_W  = 2;
    localparam int PAGE_LO = 8;
    localparam logic [BANK_W-1:0] BANK_DRAM = 2'h0;
    localparam logic [BANKS-1:0] SEL_IDLE = 4'hf;

    typedef enum logic [2:0] {
        EPB_FMT_W32,
        EPB_FMT_W40,
        EPB_FMT_W16,
        EPB_FMT_B8
    } epb_fmt_t;

    // Place a word onto the lanes its format uses
    function automatic logic [DATA_W-1:0] epb_pack(
        input epb_fmt_t f, input logic [39:0] v);
        logic [DATA_W-1:0] r;
        r = '0;
        case (f)
            EPB_FMT_W32: r[47:16] = v[31:0];
            EPB_FMT_W40: r[47:8]  = v[39:0];
            EPB_FMT_W16: r[31:16] = v[15:0];
            EPB_FMT_B8:  r[23:16] = v[7:0];
            default:     r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [39:0] epb_unpack(
        input epb_fmt_t f, input logic [DATA_W-1:0] d);
        logic [39:0] r;
        r = '0;
        case (f)
            EPB_FMT_W32: r[31:0] = d[47:16];
            EPB_FMT_W40: r       = d[47:8];
            EPB_FMT_W16: r[15:0] = d[31:16];
            EPB_FMT_B8:  r[7:0]  = d[23:16];
            default:     r = '0;
        endcase
        return r;
    endfunction
endpackage

// File: epb_if.sv
// Pin bundle of the external port bus: one master end, one slave end.
// Low-active strobes; ack is open-drain style, resolved by the testbench.
`timescale 1ns/100ps
`default_nettype none
interface epb_if;
    import epb_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              addr_oe;
    logic [DATA_W-1:0] m_data;
    logic              m_data_oe;
    logic [DATA_W-1:0] s_data;
    logic              s_data_oe;
    logic [BANKS-1:0]  bank_chip_select_n;
    logic              rd_n;
    logic              wr_n;
    logic              early_store_select_n;
    logic              strobe_oe;
    logic              page;
    logic              ack_s_o;
    logic              ack_s_oe;
    logic              ack;

    modport master (
        output addr, addr_oe, m_data, m_data_oe, bank_chip_select_n,
        output rd_n, wr_n, early_store_select_n, strobe_oe, page,
        input  s_data, s_data_oe, ack
    );
    modport slave (
        input  addr, addr_oe, m_data, m_data_oe, rd_n, wr_n,
        input  early_store_select_n, strobe_oe,
        output s_data, s_data_oe, ack_s_o, ack_s_oe
    );
endinterface
`default_nettype wire

// File: epb_slave.sv
// Slave end: lets an outside master reach internal memory and I/O registers.
// Assumes the user side answers one access at a time via mem_ready_i.
`timescale 1ns/100ps
`default_nettype none
module epb_slave
    import epb_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Internal memory side
    output logic                   mem_valid_o,
    output logic                   mem_write_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic [DATA_W-1:0]      mem_wdata_o,
    input  wire logic              mem_ready_i,
    input  wire logic [DATA_W-1:0] mem_rdata_i,
    // Bus pins
    epb_if.slave                   bus
);
    typedef enum logic [1:0] {EPB_S_IDLE, EPB_S_BUSY, EPB_S_END} epb_sst_t;

    typedef struct packed {
        epb_sst_t          st;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              drive;
    } epb_slv_t;

    epb_slv_t s_q;
    epb_slv_t s_d;
    logic     strobe;

    // Bus inputs are synchronous to the shared clock, so no resync here
    assign strobe = !bus.rd_n || !bus.wr_n; // R11 R22

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            EPB_S_IDLE:
            begin
                s_d.drive = 1'b0;
                if (strobe)
                begin
                    s_d.st    = EPB_S_BUSY;
                    s_d.addr  = bus.addr; // R20
                    s_d.write = !bus.early_store_select_n; // R15 R16
                    s_d.wdata = bus.m_data;
                end
            end
            EPB_S_BUSY:
                if (mem_ready_i)
                begin
                    s_d.st    = EPB_S_END;
                    s_d.rdata = mem_rdata_i;
                    s_d.drive = !s_q.write;
                end
            EPB_S_END:
                // Wait for the strobe to go away before taking another
                if (!strobe)
                    s_d.st = EPB_S_IDLE;
            default: s_d.st = EPB_S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_q    <= '0;
            s_q.st <= EPB_S_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign mem_valid_o = (s_q.st == EPB_S_BUSY);
    assign mem_write_o = s_q.write;
    assign mem_addr_o  = s_q.addr;
    assign mem_wdata_o = s_q.wdata;

    // Ack held low from strobe until memory has answered
    assign bus.ack_s_o  = 1'b0;
    assign bus.ack_s_oe = (s_q.st == EPB_S_BUSY) ||
                          ((s_q.st == EPB_S_IDLE) && strobe); // R18
    assign bus.s_data    = s_q.rdata;
    assign bus.s_data_oe = s_q.drive && !bus.rd_n;
endmodule
`default_nettype wire

// File: epb_asserts.sv
// Pin checker for the link between the master and slave ends.
// Assumes one shared clock and the testbench's resolved ack line.
`timescale 1ns/100ps
`default_nettype none
module epb_asserts
    import epb_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Bus pins
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              addr_oe,
    input  wire logic              m_data_oe,
    input  wire logic [BANKS-1:0]  bank_chip_select_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              early_store_select_n,
    input  wire logic              strobe_oe,
    input  wire logic              page,
    input  wire logic              ack,
    input  wire logic              ack_s_oe,
    input  wire logic              s_data_oe
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic sel = bank_chip_select_n != SEL_IDLE;
    wire logic stb = !rd_n || !wr_n;

    one_select_a: assert property (
        sel |-> $onehot(~bank_chip_select_n)) else $error("two selects");
    sel_decode_a: assert property (
        sel |-> !bank_chip_select_n[addr[BANK_LO+:BANK_W]])
        else $error("select does not match address");
    sel_with_strobe_a: assert property (
        stb |-> sel) else $error("strobe without select");
    page_bank0_a: assert property (
        page |-> !bank_chip_select_n[0]) else $error("page flag off bank 0");
    strobe_excl_a: assert property (
        !(!rd_n && !wr_n)) else $error("read and write strobes together");
    master_drives_a: assert property (
        stb |-> strobe_oe) else $error("strobe low while not driven");
    early_store_a: assert property (
        $fell(wr_n) |-> !$past(early_store_select_n) && !early_store_select_n)
        else $error("write strobe without early store select");
    ack_wait_a: assert property (
        stb && !ack |=> $stable({rd_n, wr_n})) else $error("access ended early");
    ack_end_a: assert property (
        stb && ack |=> rd_n && wr_n) else $error("strobe held after ack");
    slave_ack_a: assert property (
        $fell(rd_n) || $fell(wr_n) |-> ack_s_oe) else $error("no slave wait");
    slave_data_a: assert property (
        s_data_oe |-> !rd_n) else $error("slave drives data off read");
    wr_data_a: assert property (
        m_data_oe == !wr_n) else $error("write data drive off strobe");
    addr_drive_a: assert property (
        sel |-> addr_oe) else $error("select without address drive");

    cover property ($fell(rd_n));
    cover property ($fell(wr_n));
    cover property (!rd_n && !ack ##1 !rd_n && !ack);
    cover property (page);
endmodule
`default_nettype wire

// File: tb_top.sv
// Both bus ends joined through one interface, with a memory stub.
// Assumes a pull-up on ack: low only when the slave or the bench pulls.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
        end \
    end
module tb_top;
    import epb_pkg::*;
    logic              clk_i = 0;
    logic              sys_rst_i = 1;
    logic              req_valid_i = 0;
    logic              req_write_i = 0;
    logic              req_cond_true_i = 1;
    logic              is_master_i = 1;
    epb_fmt_t          req_fmt_i = EPB_FMT_W32;
    logic [ADDR_W-1:0] req_addr_i = '0;
    logic [39:0]       req_wdata_i = 40'h123456789a;
    logic              req_ready_o, done_o, mem_valid_o, mem_write_o;
    logic              mem_ready_i = 0;
    logic              ext_wait = 0;
    logic              ack_float = 0;
    logic              pg;
    logic [39:0]       rdata_o;
    logic [ADDR_W-1:0] mem_addr_o;
    logic [DATA_W-1:0] mem_wdata_o;
    logic [DATA_W-1:0] mem_rdata_i = 48'hfedcba987654;
    logic [39:0]       exp_w [4] = '{40'h3456789a, 40'h123456789a,
                                     40'h789a, 40'h9a};
    logic [39:0]       exp_r [4] = '{40'hfedcba98, 40'hfedcba9876,
                                     40'hba98, 40'h98};
    logic [31:0]       pa [5] = '{32'h100, 32'h104, 32'h200,
                                  32'h0400_0300, 32'h208};
    logic              pe [5] = '{0, 0, 1, 0, 0};
    int                mismatches = 0, compares = 0, hits = 0, h, lat;
    epb_if bus();
    // With ack_float set nobody drives ack and the master's keeper rules
    assign bus.ack = ack_float ? 1'bz :
        !((bus.ack_s_oe && !bus.ack_s_o) || ext_wait);

    epb_master i_epb_master (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_write_i(req_write_i), .req_cond_true_i(req_cond_true_i),
        .req_fmt_i(req_fmt_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .is_master_i(is_master_i),
        .done_o(done_o), .rdata_o(rdata_o), .bus(bus.master));
    epb_slave i_epb_slave (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_ready_i(mem_ready_i), .mem_rdata_i(mem_rdata_i),
        .bus(bus.slave));
    epb_asserts i_epb_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr(bus.addr), .bank_chip_select_n(bus.bank_chip_select_n),
        .addr_oe(bus.addr_oe), .m_data_oe(bus.m_data_oe),
        .rd_n(bus.rd_n), .wr_n(bus.wr_n), .page(bus.page),
        .early_store_select_n(bus.early_store_select_n),
        .strobe_oe(bus.strobe_oe), .ack(bus.ack),
        .ack_s_oe(bus.ack_s_oe), .s_data_oe(bus.s_data_oe));

    initial forever #5 clk_i = ~clk_i;
    // Memory stub answers one cycle after each request
    always @(negedge clk_i) mem_ready_i <= mem_valid_o && !mem_ready_i;
    always @(posedge clk_i) if (mem_valid_o && mem_ready_i) hits++;

    function automatic logic [39:0] lane(logic [47:0] d, epb_fmt_t f);
        case (f)
            EPB_FMT_W32: return {8'h0, d[47:16]};
            EPB_FMT_W40: return d[47:8];
            EPB_FMT_W16: return {24'h0, d[31:16]};
            default:     return {32'h0, d[23:16]};
        endcase
    endfunction

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Entered at a falling edge; lat counts edges from take to done
    task automatic xfer(input logic w, c, input epb_fmt_t f,
                        input logic [31:0] a);
        req_write_i = w;
        req_cond_true_i = c;
        req_fmt_i = f;
        req_addr_i = a;
        req_valid_i = 1;
        @(negedge clk_i);
        req_valid_i = 0;
        lat = 1;
        pg = bus.page;
        while (done_o !== 1'b1 && lat < 40)
        begin
            @(negedge clk_i);
            lat++;
            pg |= bus.page;
        end
        if (lat >= 40)
        begin
            mismatches++;
            complete_run();
        end
    endtask

    initial
    begin
        repeat (20) @(negedge clk_i);
        sys_rst_i = 0;
        `CHK(bus.bank_chip_select_n, 4'hf)
        `CHK({bus.rd_n, bus.wr_n, bus.early_store_select_n, bus.page}, 4'he)
        for (int i = 0; i < 4; i++)
        begin
            xfer(1, 1, epb_fmt_t'(i), 32'h0400_0010);
            `CHK(mem_write_o, 1'b1)
            `CHK(mem_addr_o, 32'h0400_0010)
            `CHK(lane(mem_wdata_o, epb_fmt_t'(i)), exp_w[i])
            xfer(0, 1, epb_fmt_t'(i), 32'h0800_0020);
            `CHK(mem_write_o, 1'b0)
            `CHK(rdata_o, exp_r[i])
        end
        `CHK(hits, 8)
        h = hits;
        xfer(1, 0, EPB_FMT_W32, 32'h0400_0040);
        `CHK(lat, 2)
        `CHK(hits, h)
        ext_wait = 1;
        fork
            xfer(0, 1, EPB_FMT_W32, 32'h0400_0050);
            begin
                repeat (4) @(negedge clk_i);
                // Ack left floating for two samples: keeper holds it low
                ext_wait = 0;
                ack_float = 1;
                repeat (2) @(negedge clk_i);
                ack_float = 0;
            end
        join
        // Take, address, strobe, plus four low samples of ack
        `CHK(lat, 7)
        for (int i = 0; i < 5; i++)
        begin
            xfer(0, 1, EPB_FMT_W32, pa[i]);
            `CHK(pg, pe[i])
        end
        is_master_i = 0;
        @(negedge clk_i);
        `CHK(req_ready_o, 1'b0)
        `CHK(bus.strobe_oe, 1'b0)
        complete_run();
    end
endmodule
`default_nettype wire
